// >>> mrd_pkg.sv
// shared constants for the move-based core decoder
package mrd_pkg;
    localparam int INSTR_W = 16;
    localparam int DATA_W = 16;
    localparam int ACC_W = 8;
    localparam int STACK_DEPTH = 4;
    localparam int SP_W = 2;
    localparam logic [SP_W-1:0] SP_RESET = 2'h3;
    localparam int NUM_DP = 3;
    // instruction fields
    localparam int FMT_BIT = 15;
    localparam int SRC_MOD_LO = 0;
    localparam int SRC_IDX_LO = 4;
    localparam int DST_MOD_LO = 8;
    localparam int DST_SUB_LO = 12;
    localparam int DST_IDX_W = 5;
    // prefix bits that extend the destination index
    localparam int PFX_DST_LO = 0;
    localparam int PFX_DST_W = 2;
    // register modules
    localparam logic [3:0] MOD_MEM = 4'h0;
    localparam logic [3:0] MOD_ALU = 4'h1;
    localparam logic [3:0] MOD_ACC = 4'h9;
    localparam logic [3:0] MOD_PFX = 4'hb;
    localparam logic [3:0] MOD_IP = 4'hc;
    localparam logic [3:0] MOD_SP = 4'hd;
    localparam logic [3:0] MOD_DPC = 4'he;
    localparam logic [3:0] MOD_DP = 4'hf;
    // indices inside modules
    localparam logic [4:0] IDX_IP_JUMP = 5'h00;
    localparam logic [4:0] IDX_IP_CALL = 5'h01;
    localparam logic [4:0] IDX_IP_RET = 5'h02;
    localparam logic [4:0] IDX_STK_DATA = 5'h00;
    localparam logic [4:0] IDX_SP = 5'h01;
    localparam logic [4:0] IDX_DPC = 5'h04;
    localparam logic [4:0] IDX_DP_STEP = 5'h04;
    localparam logic [4:0] IDX_DP_BASE = 5'h03;
    // alu operations, selected by destination index
    localparam logic [4:0] ALU_ADD = 5'h00;
    localparam logic [4:0] ALU_SUB = 5'h01;
    localparam logic [4:0] ALU_AND = 5'h02;
    localparam logic [4:0] ALU_OR = 5'h03;
    localparam logic [4:0] ALU_XOR = 5'h04;
    // data pointer mode bits, three per pointer
    localparam int DPM_W = 3;
    localparam int DPM_EN = 0;
    localparam int DPM_DEC = 1;
    localparam int DPM_PRE = 2;
    // memory map, word/byte counts
    localparam logic [15:0] ROM_BASE = 16'h8000;
    localparam logic [15:0] ROM_WORDS = 16'h0800;
    localparam logic [15:0] PROG_BASE = 16'h0000;
    localparam logic [15:0] PROG_WORDS = 16'h0400;
    localparam logic [15:0] SRAM_BASE = 16'h0000;
    localparam logic [15:0] SRAM_BYTES = 16'h0040;
    localparam logic [15:0] DEE_BASE = 16'h0040;
    localparam logic [15:0] DEE_BYTES = 16'h0080;
    localparam logic [15:0] DCODE_BASE = 16'ha000;
    localparam logic [15:0] PDATA_BASE = 16'h8000;
    typedef enum logic [1:0] {MAP_HARVARD, MAP_UNIFIED, MAP_CODE_AS_DATA}
        mrd_map_t;
    typedef enum logic [1:0] {REG_NONE, REG_ROM, REG_PROG, REG_DATA}
        mrd_region_t;
endpackage

// >>> mrd_stack.sv
// four-entry hardware return and data stack
module mrd_stack #(
    parameter int DEPTH = mrd_pkg::STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic push,
    input wire logic pop,
    input wire logic [mrd_pkg::DATA_W-1:0] push_data,
    output logic [mrd_pkg::DATA_W-1:0] top_data,
    output logic [mrd_pkg::SP_W-1:0] sp
);
    import mrd_pkg::*;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [SP_W-1:0] sp_r;
    wire [SP_W-1:0] sp_inc = sp_r + 1'b1;
    wire [SP_W-1:0] sp_dec = sp_r - 1'b1;

    assign top_data = mem[sp_r];
    assign sp = sp_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sp_r <= SP_RESET;
        end else if (push && pop) begin
            mem[sp_r] <= push_data; // pop then push replaces the top
        end else if (push) begin
            sp_r <= sp_inc;
            mem[sp_inc] <= push_data;
        end else if (pop) begin
            sp_r <= sp_dec;
        end
    end

    // checked one edge after a sampled reset, so the very first edge is safe
    AST_STACK_RESET: assert property (@(posedge ref_clk)
        reset |=> sp_r == SP_RESET)
        else $error("stack pointer not at top after reset");
    AST_STACK_LIFO: assert property (@(posedge ref_clk)
        disable iff (reset)
        push && !pop ##1 pop && !push |-> top_data == $past(push_data))
        else $error("pop did not return last pushed word");
endmodule

// >>> mrd_data_ptr.sv
// one auto-stepping data pointer
module mrd_data_ptr (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [mrd_pkg::DATA_W-1:0] load_val,
    input wire logic access,
    input wire logic [mrd_pkg::DPM_W-1:0] mode,
    output logic [mrd_pkg::DATA_W-1:0] eff_addr,
    output logic [mrd_pkg::DATA_W-1:0] ptr
);
    import mrd_pkg::*;
    logic [DATA_W-1:0] ptr_r;
    wire [DATA_W-1:0] adj = mode[DPM_DEC] ? ptr_r - 1'b1 : ptr_r + 1'b1;
    wire [DATA_W-1:0] stepped = mode[DPM_EN] ? adj : ptr_r;

    // pre mode uses the stepped value for this very access
    assign eff_addr = mode[DPM_PRE] ? stepped : ptr_r;
    assign ptr = ptr_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ptr_r <= '0;
        end else if (load) begin
            ptr_r <= load_val; // an explicit load beats the step
        end else if (access) begin
            ptr_r <= stepped;
        end
    end

    AST_DP_STEP: assert property (@(posedge ref_clk)
        disable iff (reset)
        access && !load && mode[DPM_EN] |=>
        ptr_r == ($past(mode[DPM_DEC]) ? $past(ptr_r) - 16'h0001
                                         : $past(ptr_r) + 16'h0001))
        else $error("data pointer did not step after access");
endmodule

// >>> mrd_core_decoder.sv
// fetch, decode and transport-triggered execute for the move core
module mrd_core_decoder (
    input wire logic ref_clk,
    input wire logic reset,
    input wire mrd_pkg::mrd_map_t map_mode,
    input wire logic [mrd_pkg::INSTR_W-1:0] instr_in,
    output logic [mrd_pkg::DATA_W-1:0] fetch_addr,
    output mrd_pkg::mrd_region_t fetch_region,
    output logic [mrd_pkg::DATA_W-1:0] dmem_addr,
    output mrd_pkg::mrd_region_t dmem_region,
    output logic dmem_rd,
    input wire logic [mrd_pkg::DATA_W-1:0] dmem_rdata,
    output logic dmem_we,
    output logic [mrd_pkg::DATA_W-1:0] dmem_waddr,
    output logic [mrd_pkg::DATA_W-1:0] dmem_wdata,
    output logic ext_rd,
    output logic [3:0] ext_rd_module,
    output logic [3:0] ext_rd_index,
    input wire logic [mrd_pkg::DATA_W-1:0] ext_rd_data,
    output logic ext_wr,
    output logic [3:0] ext_wr_module,
    output logic [mrd_pkg::DST_IDX_W-1:0] ext_wr_index,
    output logic [mrd_pkg::DATA_W-1:0] ext_wr_data,
    output logic [mrd_pkg::ACC_W-1:0] acc,
    output logic [mrd_pkg::SP_W-1:0] stack_level
);
    import mrd_pkg::*;

    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] base,
                                      input logic [15:0] size);
        logic [16:0] top;
        top = {1'b0, base} + {1'b0, size};
        in_range = (a >= base) && ({1'b0, a} < top);
    endfunction

    // architectural state
    logic [DATA_W-1:0] ip_r, ip_nxt;
    logic [ACC_W-1:0] acc_r, acc_nxt;
    logic [PFX_DST_W-1:0] destination_prefix_register_r;
    logic [NUM_DP*DPM_W-1:0] dpc_r;
    logic ext_wr_r;
    logic [3:0] ext_wr_module_r;
    logic [DST_IDX_W-1:0] ext_wr_index_r;
    logic [DATA_W-1:0] ext_wr_data_r;
    logic dmem_we_r;
    logic [DATA_W-1:0] dmem_waddr_r, dmem_wdata_r;

    // field decode; every instruction is one word, no length decode
    wire src_is_reg = instr_in[FMT_BIT];
    wire [7:0] src_field = instr_in[7:0];
    wire [3:0] src_mod = src_field[SRC_MOD_LO +: 4];
    wire [3:0] src_idx = src_field[SRC_IDX_LO +: 4];
    wire [3:0] dst_mod = instr_in[DST_MOD_LO +: 4];
    wire [2:0] dst_sub = instr_in[DST_SUB_LO +: 3];
    // upper index bits come from the prefix loaded just before
    wire [DST_IDX_W-1:0] dst_idx =
        {destination_prefix_register_r, dst_sub};

    // destination decode
    wire wr_mem = dst_mod == MOD_MEM;
    wire wr_alu = dst_mod == MOD_ALU;
    wire wr_acc = dst_mod == MOD_ACC;
    wire wr_pfx = dst_mod == MOD_PFX;
    wire wr_ip = dst_mod == MOD_IP;
    wire wr_sp = dst_mod == MOD_SP;
    wire wr_dpc = dst_mod == MOD_DPC && dst_idx == IDX_DPC;
    wire wr_dp = dst_mod == MOD_DP;
    wire is_jump = wr_ip && dst_idx == IDX_IP_JUMP;
    wire is_call = wr_ip && dst_idx == IDX_IP_CALL;
    wire is_ret = wr_ip && dst_idx == IDX_IP_RET;
    wire is_push = wr_sp && dst_idx == IDX_STK_DATA;
    wire wr_internal = wr_mem | wr_alu | wr_acc | wr_pfx | wr_ip | wr_sp
                     | wr_dpc | wr_dp;

    // source decode; only register sources trigger read side effects
    wire rd_mem = src_is_reg && src_mod == MOD_MEM;
    wire rd_stack = src_is_reg && src_mod == MOD_SP
                    && src_idx == IDX_STK_DATA[3:0];
    wire rd_sp = src_is_reg && src_mod == MOD_SP && src_idx == IDX_SP[3:0];
    wire rd_acc = src_is_reg && src_mod == MOD_ACC;
    wire rd_ip = src_is_reg && src_mod == MOD_IP;
    wire rd_dp = src_is_reg && src_mod == MOD_DP;
    wire rd_dpc = src_is_reg && src_mod == MOD_DPC
                  && src_idx == IDX_DPC[3:0];
    wire rd_internal = rd_mem | rd_stack | rd_sp | rd_acc | rd_ip
                     | rd_dp | rd_dpc;

    // stack and data pointers
    wire [DATA_W-1:0] stk_top;
    wire [SP_W-1:0] sp_val;
    wire [DATA_W-1:0] ip_inc = ip_r + 1'b1;
    wire stk_pop = rd_stack | is_ret;
    wire stk_push = is_push | is_call;
    logic [DATA_W-1:0] src_val;
    wire [DATA_W-1:0] stk_wdata = is_call ? ip_inc : src_val;

    mrd_stack u_stack (
        .ref_clk(ref_clk),
        .reset(reset),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(stk_wdata),
        .top_data(stk_top),
        .sp(sp_val)
    );

    // pointer k sits at index base + 4k; memory access k at index k
    wire [DATA_W-1:0] dp_eff [NUM_DP];
    wire [DATA_W-1:0] dp_val [NUM_DP];
    wire [1:0] mem_sel_rd = src_idx[1:0];
    wire [1:0] mem_sel_wr = dst_idx[1:0];
    for (genvar k = 0; k < NUM_DP; k++) begin : g_dp
        localparam logic [4:0] DP_IDX = 5'(IDX_DP_BASE + k * IDX_DP_STEP);
        wire dp_load = wr_dp && dst_idx == DP_IDX;
        wire dp_acc = (rd_mem && mem_sel_rd == 2'(k))
                    || (wr_mem && mem_sel_wr == 2'(k));
        mrd_data_ptr u_dp (
            .ref_clk(ref_clk),
            .reset(reset),
            .load(dp_load),
            .load_val(src_val),
            .access(dp_acc),
            .mode(dpc_r[k*DPM_W +: DPM_W]),
            .eff_addr(dp_eff[k]),
            .ptr(dp_val[k])
        );
    end

    // one pointer serves a memory move, the read side picks first
    wire [1:0] mem_sel = rd_mem ? mem_sel_rd : mem_sel_wr;
    wire mem_sel_ok = 32'(mem_sel) < NUM_DP;
    wire [DATA_W-1:0] mem_addr = mem_sel_ok ? dp_eff[mem_sel] : '0;
    wire [1:0] dp_rd_sel = src_idx[3:2];
    wire [DATA_W-1:0] dp_rd_val =
        32'(dp_rd_sel) < NUM_DP ? dp_val[dp_rd_sel] : '0;

    // source mux
    always_comb begin
        if (!src_is_reg) begin
            src_val = {8'h00, src_field};
        end else if (rd_mem) begin
            src_val = dmem_rdata;
        end else if (rd_stack) begin
            src_val = stk_top;
        end else if (rd_sp) begin
            src_val = {{(DATA_W-SP_W){1'b0}}, sp_val};
        end else if (rd_acc) begin
            src_val = {8'h00, acc_r};
        end else if (rd_ip) begin
            src_val = ip_r;
        end else if (rd_dp) begin
            src_val = dp_rd_val;
        end else if (rd_dpc) begin
            src_val = {{(DATA_W-NUM_DP*DPM_W){1'b0}}, dpc_r};
        end else begin
            src_val = ext_rd_data;
        end
    end

    // alu: accumulator against any source
    always_comb begin
        acc_nxt = acc_r;
        if (wr_acc) begin
            acc_nxt = src_val[ACC_W-1:0];
        end else if (wr_alu) begin
            unique case (dst_idx)
                ALU_ADD: acc_nxt = acc_r + src_val[ACC_W-1:0];
                ALU_SUB: acc_nxt = acc_r - src_val[ACC_W-1:0];
                ALU_AND: acc_nxt = acc_r & src_val[ACC_W-1:0];
                ALU_OR: acc_nxt = acc_r | src_val[ACC_W-1:0];
                ALU_XOR: acc_nxt = acc_r ^ src_val[ACC_W-1:0];
                default: acc_nxt = acc_r;
            endcase
        end
    end

    // next fetch address: one instruction per clock, no pipeline
    always_comb begin
        if (is_jump || is_call) begin
            ip_nxt = src_val;
        end else if (is_ret) begin
            ip_nxt = stk_top;
        end else begin
            ip_nxt = ip_inc;
        end
    end

    // memory mapping
    wire code_as_data = map_mode == MAP_CODE_AS_DATA;
    wire unified = map_mode == MAP_UNIFIED;
    assign fetch_region =
        in_range(ip_r, ROM_BASE, ROM_WORDS) ? REG_ROM :
        in_range(ip_r, PROG_BASE, PROG_WORDS) ? REG_PROG :
        unified && in_range(ip_r, DCODE_BASE, DEE_BYTES + SRAM_BYTES)
            ? REG_DATA : REG_NONE;
    assign dmem_region =
        in_range(mem_addr, SRAM_BASE, SRAM_BYTES + DEE_BYTES)
            ? REG_DATA :
        code_as_data && in_range(mem_addr, PDATA_BASE, PROG_WORDS)
            ? REG_PROG : REG_NONE;
    assign fetch_addr = ip_r;
    assign dmem_addr = mem_addr;
    assign dmem_rd = rd_mem;

    // register-module access to modules outside the core
    assign ext_rd = src_is_reg && !rd_internal;
    assign ext_rd_module = src_mod;
    assign ext_rd_index = src_idx;
    assign ext_wr = ext_wr_r;
    assign ext_wr_module = ext_wr_module_r;
    assign ext_wr_index = ext_wr_index_r;
    assign ext_wr_data = ext_wr_data_r;
    assign dmem_we = dmem_we_r;
    assign dmem_waddr = dmem_waddr_r;
    assign dmem_wdata = dmem_wdata_r;
    assign acc = acc_r;
    assign stack_level = sp_val;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ip_r <= PROG_BASE;
            acc_r <= '0;
            dpc_r <= '0;
        end else begin
            ip_r <= ip_nxt;
            acc_r <= acc_nxt;
            if (wr_dpc) begin
                dpc_r <= src_val[NUM_DP*DPM_W-1:0];
            end
        end
    end

    // prefix holds for exactly one following instruction
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            destination_prefix_register_r <= '0;
        end else if (wr_pfx) begin
            destination_prefix_register_r <=
                src_val[PFX_DST_LO +: PFX_DST_W];
        end else begin
            destination_prefix_register_r <= '0;
        end
    end

    // writes leave registered so modules see stable data; reads stay live
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ext_wr_r <= 1'b0;
            dmem_we_r <= 1'b0;
        end else begin
            ext_wr_r <= !wr_internal;
            dmem_we_r <= wr_mem;
        end
        ext_wr_module_r <= dst_mod;
        ext_wr_index_r <= dst_idx;
        ext_wr_data_r <= src_val;
        dmem_waddr_r <= mem_addr;
        dmem_wdata_r <= src_val;
    end

    AST_SINGLE_CYCLE: assert property (@(posedge ref_clk)
        disable iff (reset)
        !reset && !is_jump && !is_call && !is_ret |=> ip_r == $past(ip_inc))
        else $error("fetch address did not advance by one");
    AST_JUMP_TARGET: assert property (@(posedge ref_clk)
        disable iff (reset)
        is_call |=> ip_r == $past(src_val) && stk_top == $past(ip_inc))
        else $error("call did not jump or save return address");
    AST_IMM_LOAD: assert property (@(posedge ref_clk)
        disable iff (reset)
        wr_acc && !instr_in[FMT_BIT] |=> acc_r == $past(instr_in[7:0]))
        else $error("immediate source not loaded into accumulator");
    AST_ALU_ADD: assert property (@(posedge ref_clk)
        disable iff (reset)
        wr_alu && dst_idx == ALU_ADD
        |=> acc_r == 8'($past(acc_r) + $past(src_val[ACC_W-1:0])))
        else $error("alu add result wrong");
    AST_PFX_DEST: assert property (@(posedge ref_clk)
        disable iff (reset)
        wr_pfx ##1 (!wr_internal && !wr_pfx) |=>
        ext_wr && ext_wr_index[DST_IDX_W-1 -: PFX_DST_W]
            == $past(src_val[PFX_DST_LO +: PFX_DST_W], 2))
        else $error("prefix bits missing from destination index");
    AST_PFX_CLEAR: assert property (@(posedge ref_clk)
        disable iff (reset)
        wr_pfx ##1 !wr_pfx |=> destination_prefix_register_r == '0)
        else $error("prefix outlived the next instruction");
    AST_PFX_COST: assert property (@(posedge ref_clk)
        disable iff (reset)
        wr_pfx ##1 (!is_jump && !is_call && !is_ret)
        |=> ip_r == $past(ip_r, 2) + 16'h0002)
        else $error("prefix did not cost exactly one cycle");
    AST_HARVARD: assert property (@(posedge ref_clk)
        disable iff (reset)
        map_mode == MAP_HARVARD |-> fetch_region != REG_DATA
            && dmem_region != REG_PROG)
        else $error("spaces mixed in separate mapping mode");
endmodule

// >>> mrd_prog_model.sv
// behavioural program memory, external registers and data memory partner
module mrd_prog_model (
    input wire logic ref_clk,
    input wire logic [15:0] fetch_addr,
    output logic [15:0] instr_in,
    input wire logic ext_rd,
    input wire logic [3:0] ext_rd_module,
    input wire logic [3:0] ext_rd_index,
    output logic [15:0] ext_rd_data,
    input wire logic dmem_rd,
    input wire logic [15:0] dmem_addr,
    output logic [15:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // unloaded words copy the accumulator onto itself: no visible side effect
    localparam logic [15:0] IDLE_WORD = 16'h8909;
    logic [15:0] mem [0:255];
    logic [15:0] churn_r = 16'h1d2e;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = IDLE_WORD;
        end
    end
    // unselected answers change every cycle so a stale sample never matches
    always @(posedge ref_clk) begin
        churn_r <= {churn_r[14:0], ~churn_r[15]};
    end
    assign instr_in = mem[fetch_addr[7:0]];
    assign ext_rd_data = ext_rd ? {ext_rd_index, ext_rd_module, 8'h3c}
                                : ~churn_r;
    assign dmem_rdata = dmem_rd ? (dmem_addr ^ 16'h5a5a) : churn_r;
endmodule

// >>> tb.sv
// self-checking bench for the move core decoder
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("FAIL %0t %s", $time, m); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mrd_pkg::*;
    typedef struct {logic [3:0] md; logic [4:0] ix; logic [15:0] dt;} mrd_exp_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    mrd_map_t map_mode = MAP_HARVARD;
    logic [15:0] instr_in, fetch_addr, dmem_addr, dmem_rdata, dmem_waddr;
    logic [15:0] dmem_wdata, ext_rd_data, ext_wr_data;
    mrd_region_t fetch_region, dmem_region, er;
    logic dmem_rd, dmem_we, ext_rd, ext_wr;
    logic [3:0] ext_rd_module, ext_rd_index, ext_wr_module;
    logic [4:0] ext_wr_index;
    logic [7:0] acc, a, b, e;
    logic [1:0] stack_level;
    logic [15:0] pc;
    int fails = 0;
    int num_checks = 0;
    mrd_exp_t q[$];
    mrd_exp_t got;
    always #5 ref_clk = ~ref_clk;
    mrd_core_decoder uut (.ref_clk(ref_clk), .reset(reset),
        .map_mode(map_mode), .instr_in(instr_in), .fetch_addr(fetch_addr),
        .fetch_region(fetch_region), .dmem_addr(dmem_addr),
        .dmem_region(dmem_region), .dmem_rd(dmem_rd),
        .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_waddr(dmem_waddr),
        .dmem_wdata(dmem_wdata), .ext_rd(ext_rd),
        .ext_rd_module(ext_rd_module), .ext_rd_index(ext_rd_index),
        .ext_rd_data(ext_rd_data), .ext_wr(ext_wr),
        .ext_wr_module(ext_wr_module), .ext_wr_index(ext_wr_index),
        .ext_wr_data(ext_wr_data), .acc(acc), .stack_level(stack_level));
    mrd_prog_model pm (.ref_clk(ref_clk), .fetch_addr(fetch_addr),
        .instr_in(instr_in), .ext_rd(ext_rd), .ext_rd_module(ext_rd_module),
        .ext_rd_index(ext_rd_index), .ext_rd_data(ext_rd_data),
        .dmem_rd(dmem_rd), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata));
    // each external write strobe retires the oldest expected transfer
    always @(posedge ref_clk) begin
        if (reset === 1'b0 && ext_wr !== 1'b0) begin
            if (q.size() == 0) begin
                `CHK(ext_wr, 1'b0, "unexpected external write")
            end else begin
                got = q.pop_front();
                `CHK(ext_wr_module, got.md, "ext module")
                `CHK(ext_wr_index, got.ix, "ext index")
                `CHK(ext_wr_data, got.dt, "ext data")
            end
        end
    end
    task automatic put(input logic [15:0] w);
        @(negedge ref_clk);
        pm.mem[fetch_addr[7:0]] = w;
        #1;
    endtask
    task automatic run();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic exec(input logic [15:0] w);
        put(w);
        run();
    endtask
    task automatic expect_wr(input logic [3:0] m, input logic [4:0] i,
                             input logic [15:0] d);
        mrd_exp_t x;
        x.md = m;
        x.ix = i;
        x.dt = d;
        q.push_back(x);
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(5000 * 10);
        fails++;
        close_out();
    end
    initial begin
        a = 8'($urandom(97827));
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK(fetch_addr, 16'h0000, "reset ip")
        `CHK(acc, 8'h00, "reset acc")
        `CHK(stack_level, 2'h3, "reset stack level")
        @(posedge ref_clk);
        map_mode <= MAP_HARVARD;
        reset <= 1'b0;
        $display("test reset done");
        // immediate loads and every alu operation with random operands
        for (int op = 0; op < 5; op++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            exec({1'b0, 3'h0, 4'h9, a});
            `CHK(acc, a, "acc load")
            pc = fetch_addr;
            exec({1'b0, 3'(op), 4'h1, b});
            case (op)
                0: e = a + b;
                1: e = a - b;
                2: e = a & b;
                3: e = a | b;
                default: e = a ^ b;
            endcase
            `CHK(acc, e, "alu result")
            `CHK(fetch_addr, pc + 16'h0001, "one word per cycle")
        end
        $display("test alu done");
        b = 8'($urandom);
        expect_wr(4'h3, 5'h05, {8'h00, b});
        exec({1'b0, 3'h5, 4'h3, b});
        // prefix reaches the upper indices for exactly the next instruction
        pc = fetch_addr;
        exec({1'b0, 3'h0, 4'hb, 8'h02});
        `CHK(fetch_addr, pc + 16'h0001, "prefix costs one cycle")
        expect_wr(4'h6, 5'h13, 16'h0021);
        exec({1'b0, 3'h3, 4'h6, 8'h21});
        expect_wr(4'h6, 5'h03, 16'h0022);
        exec({1'b0, 3'h3, 4'h6, 8'h22});
        $display("test prefix done");
        // register source from an external module
        put({1'b1, 3'h2, 4'h4, 4'h7, 4'h5});
        `CHK(ext_rd, 1'b1, "ext read strobe")
        `CHK(ext_rd_module, 4'h5, "ext read module")
        `CHK(ext_rd_index, 4'h7, "ext read index")
        expect_wr(4'h4, 5'h02, 16'h753c);
        run();
        $display("test register source done");
        // push increments the pointer first, pop reads then decrements
        exec({1'b0, 3'h0, 4'hd, 8'h77});
        `CHK(stack_level, 2'h0, "push level")
        expect_wr(4'h3, 5'h00, 16'h0077);
        exec({1'b1, 3'h0, 4'h3, 4'h0, 4'hd});
        `CHK(stack_level, 2'h3, "pop level")
        $display("test stack done");
        // pointer write, then post-increment reads
        exec({1'b0, 3'h3, 4'hf, 8'h10});
        b = 8'($urandom);
        exec({1'b0, 3'h0, 4'h0, b});
        `CHK(dmem_we, 1'b1, "data write strobe")
        `CHK(dmem_waddr, 16'h0010, "data write address")
        `CHK(dmem_wdata, {8'h00, b}, "data write value")
        exec({1'b0, 3'h4, 4'he, 8'h01});
        for (int k = 0; k < 2; k++) begin
            put({1'b1, 3'h1, 4'h3, 4'h0, 4'h0});
            `CHK(dmem_rd, 1'b1, "data read strobe")
            `CHK(dmem_addr, 16'(16 + k), "pointer step")
            `CHK(dmem_region, REG_DATA, "data region")
            expect_wr(4'h3, 5'h01, 16'(16 + k) ^ 16'h5a5a);
            run();
        end
        $display("test data pointer done");
        exec({1'b0, 3'h0, 4'hc, 8'h40});
        `CHK(fetch_addr, 16'h0040, "jump target")
        `CHK(fetch_region, REG_PROG, "program region")
        // call saves the next address, return restores it from the stack
        pc = fetch_addr;
        exec({1'b0, 3'h1, 4'hc, 8'h80});
        `CHK(fetch_addr, 16'h0080, "call target")
        `CHK(stack_level, 2'h0, "call level")
        exec({1'b0, 3'h2, 4'hc, 8'h00});
        `CHK(fetch_addr, pc + 16'h0001, "return address")
        `CHK(stack_level, 2'h3, "return level")
        // pointer 1 aims into the code window, read under every mapping
        exec({1'b1, 3'h7, 4'hf, 4'h8, 4'h3});
        for (int m = 2; m < 5; m++) begin
            @(posedge ref_clk);
            map_mode <= mrd_map_t'(m % 3);
            #1;
            put({1'b1, 3'h6, 4'h3, 4'h1, 4'h0});
            er = (m == 2) ? REG_PROG : REG_NONE;
            `CHK(dmem_addr, 16'h833c, "pointer 1 address")
            `CHK(dmem_region, er, "code as data")
            expect_wr(4'h3, 5'h06, 16'h833c ^ 16'h5a5a);
            run();
        end
        // unified mode lets a fetch land in the data window
        exec({1'b1, 3'h7, 4'hf, 4'hf, 4'ha});
        exec({1'b1, 3'h0, 4'hc, 4'h1, 4'h0});
        `CHK(fetch_addr, 16'hfa3c ^ 16'h5a5a, "pointer jump")
        `CHK(fetch_region, REG_DATA, "code from data")
        $display("test call and mapping done");
        repeat (3) run();
        `CHK(q.size(), 0, "all writes seen")
        $display("test jump done");
        close_out();
    end
endmodule
